// ### speed_pulse_stop.sv
// Speed pulse generation and motor stop sequencing
`timescale 1ns/1ns
`default_nettype none
module speed_pulse_stop
  import speed_stop_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic cfg_write_in,
  input wire logic [31:0] cfg_data_in,
  output logic [31:0] cfg_data_out,
  input wire logic comm_pulse_in,
  input wire logic closed_loop_in,
  input wire logic first_try_in,
  input wire logic driving_in,
  input wire logic [15:0] backemf_mv_in,
  input wire logic stop_req_in,
  input wire logic start_req_in,
  input wire logic [6:0] duty_pct_x2_in,
  output logic speed_pulse_output_out,
  output logic [1:0] phase_mode_out,
  output logic stopped_out
);
  typedef enum {S_RUN, S_WAIT_DUTY, S_BRAKE, S_HIZ} stop_state_e;
  logic [31:0] cfg_reg;
  logic [3:0] div_cnt_reg;
  logic pulse_reg;
  logic [31:0] brk_cnt_reg;
  stop_state_e st_reg;
  logic [1:0] sel;
  logic [3:0] div_code;
  logic [3:0] div_n;
  logic [2:0] bemf_code;
  logic [2:0] stop_code;
  logic [2:0] duty_code;
  logic [3:0] brk_code;
  logic pulse_en;
  logic duty_ok;
  logic braking;

  // Back-EMF threshold in mV per code
  function automatic logic [15:0] bemf_mv(input logic [2:0] c);
    case (c)
      3'h0: bemf_mv = 16'h0001;
      3'h1: bemf_mv = 16'h0002;
      3'h2: bemf_mv = 16'h0005;
      3'h3: bemf_mv = 16'h000A;
      3'h4: bemf_mv = 16'h0014;
      3'h5: bemf_mv = 16'h001E;
      default: bemf_mv = 16'hFFFF;
    endcase
  endfunction

  // Brake hold time in ms per code
  function automatic logic [15:0] brk_ms(input logic [3:0] c);
    case (c)
      4'h0: brk_ms = 16'h0001;
      4'h1: brk_ms = 16'h0002;
      4'h2: brk_ms = 16'h0005;
      4'h3: brk_ms = 16'h000A;
      4'h4: brk_ms = 16'h000F;
      4'h5: brk_ms = 16'h0019;
      4'h6: brk_ms = 16'h0032;
      4'h7: brk_ms = 16'h004B;
      4'h8: brk_ms = 16'h0064;
      4'h9: brk_ms = 16'h00FA;
      4'hA: brk_ms = 16'h01F4;
      4'hB: brk_ms = 16'h03E8;
      4'hC: brk_ms = 16'h09C4;
      4'hD: brk_ms = 16'h1388;
      4'hE: brk_ms = 16'h2710;
      default: brk_ms = 16'h3A98;
    endcase
  endfunction

  // Duty threshold in half percent units
  function automatic logic [6:0] duty_thr(input logic [2:0] c);
    case (c)
      3'h1: duty_thr = 7'h64;
      3'h2: duty_thr = 7'h32;
      3'h3: duty_thr = 7'h1E;
      3'h4: duty_thr = 7'h14;
      3'h5: duty_thr = 7'h0F;
      3'h6: duty_thr = 7'h0A;
      default: duty_thr = 7'h05;
    endcase
  endfunction

  // Field extraction
  assign sel = cfg_reg[SEL_LSB +: 2];
  assign div_code = cfg_reg[DIV_LSB +: 4];
  assign bemf_code = cfg_reg[BEMF_LSB +: 3];
  assign stop_code = cfg_reg[STOP_LSB +: 3];
  assign brk_code = cfg_reg[BRK_LSB +: 4];
  assign duty_code = cfg_reg[DUTY_LSB +: 3];
  assign div_n = (div_code == 4'h0) ? DIV_ZERO_AS : div_code; // [R2]
  assign cfg_data_out = cfg_reg;
  assign braking = (stop_code == STOP_LOW_BRAKE) ||
    (stop_code == STOP_HIGH_BRAKE) || (stop_code == STOP_SPIN_DOWN);
  assign duty_ok = (duty_code == 3'h0) ||
    (duty_pct_x2_in < duty_thr(duty_code)); // [R7]

  // Pulse enable from loop mode and activity config
  always_comb
  begin
    case (sel) // [R1]
      SEL_BOTH: pulse_en = 1'b1;
      SEL_CLOSED: pulse_en = closed_loop_in;
      SEL_FIRST: pulse_en = !closed_loop_in && first_try_in;
      default: pulse_en = 1'b0;
    endcase
    if (cfg_reg[CFGBIT_POS]) // [R3]
      pulse_en = pulse_en && driving_in;
    else
      pulse_en = pulse_en && (bemf_code < 3'h6) &&
        (backemf_mv_in >= bemf_mv(bemf_code)); // [R4]
  end

  // Configuration register
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      cfg_reg <= CFG_RESET;
    else if (cfg_write_in)
      cfg_reg <= cfg_data_in;
  end

  // Divided speed pulse, toggles every n commutation pulses
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt_reg <= 4'h0;
      pulse_reg <= 1'b0;
    end
    else if (!pulse_en)
    begin
      div_cnt_reg <= 4'h0;
      pulse_reg <= 1'b0;
    end
    else if (comm_pulse_in)
    begin
      if (div_cnt_reg + 4'h1 >= div_n) // [R2]
      begin
        div_cnt_reg <= 4'h0;
        pulse_reg <= !pulse_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end
  assign speed_pulse_output_out = pulse_reg;

  // Stop sequencer
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      st_reg <= S_RUN;
      brk_cnt_reg <= 32'h0;
    end
    else
    begin
      case (st_reg)
        S_RUN:
          if (stop_req_in)
            st_reg <= braking ? S_WAIT_DUTY : S_HIZ; // [R5]
        S_WAIT_DUTY:
          if (duty_ok) // [R7]
          begin
            st_reg <= S_BRAKE;
            brk_cnt_reg <= 32'(brk_ms(brk_code)) * 32'(MS_CYC); // [R6]
          end
        S_BRAKE:
          if (brk_cnt_reg <= 32'h1)
            st_reg <= S_HIZ; // [R8]
          else
            brk_cnt_reg <= brk_cnt_reg - 32'h1;
        S_HIZ:
          if (start_req_in)
            st_reg <= S_RUN;
        default: st_reg <= S_RUN;
      endcase
    end
  end

  // Phase mode output
  always_comb
  begin
    phase_mode_out = PH_OFF;
    if (st_reg == S_RUN)
      phase_mode_out = PH_RECIRC;
    else if (st_reg == S_BRAKE || st_reg == S_WAIT_DUTY)
      phase_mode_out = (stop_code == STOP_HIGH_BRAKE) ? PH_HIGH : PH_LOW;
    else if (st_reg == S_HIZ && stop_code == STOP_RECIRC)
      phase_mode_out = PH_RECIRC; // [R5]
  end
  assign stopped_out = (st_reg == S_HIZ);

  a_closed_only_gate: assert property (@(posedge clk_sys_in) // [R1]
    disable iff (!reset_n_in)
    (sel == SEL_CLOSED && !closed_loop_in) |=> !pulse_reg)
    else $error("pulse outside closed loop");
  a_unused_sel_off: assert property (@(posedge clk_sys_in) // [R1]
    disable iff (!reset_n_in) (sel == 2'h3) |=> !pulse_reg)
    else $error("pulse with unused select");
  a_div_bound: assert property (@(posedge clk_sys_in) // [R2]
    disable iff (!reset_n_in) div_cnt_reg < div_n || $changed(cfg_reg))
    else $error("divider count overflow");
  a_driven_gate: assert property (@(posedge clk_sys_in) // [R3]
    disable iff (!reset_n_in)
    (cfg_reg[CFGBIT_POS] && !driving_in) |=> !pulse_reg)
    else $error("pulse while not driven");
  a_bemf_gate: assert property (@(posedge clk_sys_in) // [R4]
    disable iff (!reset_n_in)
    (!cfg_reg[CFGBIT_POS] && bemf_code == 3'h6) |=> !pulse_reg)
    else $error("pulse with unused threshold");
  a_hiz_direct: assert property (@(posedge clk_sys_in) // [R5]
    disable iff (!reset_n_in)
    (st_reg == S_RUN && stop_req_in && !braking) |=> st_reg == S_HIZ)
    else $error("non braking stop not direct");
  a_brake_load: assert property (@(posedge clk_sys_in) // [R6]
    disable iff (!reset_n_in)
    (st_reg == S_WAIT_DUTY && duty_ok) |=>
      brk_cnt_reg == 32'(brk_ms(brk_code)) * 32'(MS_CYC))
    else $error("brake time not loaded");
  a_duty_wait: assert property (@(posedge clk_sys_in) // [R7]
    disable iff (!reset_n_in)
    (st_reg == S_WAIT_DUTY && !duty_ok) |=> st_reg == S_WAIT_DUTY)
    else $error("brake began above duty threshold");
  a_brake_end: assert property (@(posedge clk_sys_in) // [R8]
    disable iff (!reset_n_in)
    (st_reg == S_BRAKE && brk_cnt_reg <= 32'h1) |=>
      phase_mode_out == PH_OFF || stop_code == STOP_RECIRC)
    else $error("braking not released");
endmodule
`default_nettype wire

// ### speed_stop_pkg.sv
// Constants for the speed pulse and motor stop configuration block
//
// Functional notes
// R1: Pulse select 0 both loops, 1 closed only, 2 open first try, 3 unused.
// R2: Division field divides pulse rate by code; code zero divides by three.
// R3: Config bit clear: pulse until below back-EMF threshold; set: while driven.
// R4: Back-EMF threshold codes 0-5 give 1,2,5,10,20,30 mV; 6,7 unused.
// R5: Stop method: hi-Z, recirculation, low brake, high brake, spin down.
// R6: Brake time codes select 1 ms up to 15000 ms hold.
// R7: Braking stops start once duty falls below threshold; code zero immediate.
// R8: After brake time elapses, release braking and hold outputs high impedance.
package speed_stop_pkg;
  localparam int CFG_W = 32;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int SEL_LSB = 29;
  localparam int DIV_LSB = 25;
  localparam int CFGBIT_POS = 24;
  localparam int BEMF_LSB = 21;
  localparam int STOP_LSB = 18;
  localparam int BRK_LSB = 14;
  localparam int DUTY_LSB = 11;
  localparam logic [3:0] DIV_ZERO_AS = 4'h3;
  localparam int CLK_KHZ = 100000;
  localparam int MS_CYCLES = CLK_KHZ;
  localparam logic [1:0] SEL_BOTH = 2'h0;
  localparam logic [1:0] SEL_CLOSED = 2'h1;
  localparam logic [1:0] SEL_FIRST = 2'h2;
  typedef enum logic [2:0] {STOP_HIZ, STOP_RECIRC, STOP_LOW_BRAKE,
    STOP_HIGH_BRAKE, STOP_SPIN_DOWN} stop_method_e;
  typedef enum logic [1:0] {PH_OFF, PH_LOW, PH_HIGH, PH_RECIRC} phase_e;
endpackage

// ### motor_model.sv
// Motor and speed monitor model facing the speed pulse block
`timescale 1ns/1ns
`default_nettype none
module motor_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [15:0] emf_in,
  output logic comm_out,
  output logic [15:0] emf_out
);
  logic [1:0] ph_reg = 2'h0;
  // Rotor position, one commutation every four cycles while spinning
  always_ff @(posedge clk_in)
    ph_reg <= run_in ? ph_reg + 2'h1 : 2'h0;
  assign comm_out = run_in && (ph_reg == 2'h3);
  // Back-EMF magnitude seen by the monitor
  assign emf_out = emf_in;
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the speed pulse and stop block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import speed_stop_pkg::*;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0;
  logic wr = 1'b0, cl = 1'b1, ft = 1'b0, drv = 1'b1;
  logic run = 1'b0, sreq = 1'b0, go = 1'b0, comm, pulse, stopped;
  logic [31:0] wd = 32'h0, rd;
  logic [15:0] emf = 16'h03E8, emf_m;
  logic [6:0] duty = 7'h78;
  logic [1:0] phase;
  int err_count = 0, check_count = 0, cyc = 0;
  // Block under test, millisecond shortened to 10 cycles
  speed_pulse_stop #(.MS_CYC(10)) speed_pulse_stop_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .cfg_write_in(wr), .cfg_data_in(wd), .cfg_data_out(rd),
    .comm_pulse_in(comm), .closed_loop_in(cl), .first_try_in(ft),
    .driving_in(drv), .backemf_mv_in(emf_m), .stop_req_in(sreq),
    .start_req_in(go), .duty_pct_x2_in(duty),
    .speed_pulse_output_out(pulse), .phase_mode_out(phase),
    .stopped_out(stopped));
  motor_model motor_model_i (.clk_in(clk_sys_in), .run_in(run),
    .emf_in(emf), .comm_out(comm), .emf_out(emf_m));
  // Clock and hang guard
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Reset for five cycles, then one configuration write
  task automatic setup(input logic [31:0] cfg);
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    tick(5);
    reset_n_in <= 1'b1;
    wr <= 1'b1;
    wd <= cfg;
    tick(1);
    wr <= 1'b0;
    tick(1);
    #1;
    check(rd, cfg);
  endtask
  function automatic logic [31:0] cf(input logic [1:0] s,
      input logic [3:0] d, input logic c, input logic [2:0] b);
    return {1'b0, s, d, c, b, 21'h0};
  endfunction
  // Let the motor deliver n commutations, then stop it
  task automatic spin(input int n);
    run <= 1'b1;
    repeat (n)
    begin
      @(posedge clk_sys_in);
      while (comm !== 1'b1)
        @(posedge clk_sys_in);
    end
    run <= 1'b0;
    tick(2);
    #1;
  endtask
  // Pulse stays low for n-1 events, then shows x
  task automatic pc(input logic [31:0] cfg, input int n,
      input logic c, f, v, input logic [15:0] e, input logic x);
    @(posedge clk_sys_in);
    cl <= c;
    ft <= f;
    drv <= v;
    emf <= e;
    setup(cfg);
    if (n > 1)
      spin(n - 1);
    check(pulse, 1'b0);
    spin(1);
    check(pulse, x);
  endtask
  task automatic div_test();
    pc(cf(0, 0, 1, 0), 3, 1, 0, 1, 1000, 1);
    pc(cf(0, 2, 1, 0), 2, 1, 0, 1, 1000, 1);
    pc(cf(0, 15, 1, 0), 15, 1, 0, 1, 1000, 1);
  endtask
  task automatic select_test();
    pc(cf(0, 1, 1, 0), 1, 0, 0, 1, 1000, 1);
    pc(cf(1, 1, 1, 0), 1, 0, 0, 1, 1000, 0);
    pc(cf(1, 1, 1, 0), 1, 1, 0, 1, 1000, 1);
    pc(cf(2, 1, 1, 0), 1, 0, 1, 1, 1000, 1);
    pc(cf(2, 1, 1, 0), 1, 0, 0, 1, 1000, 0);
    pc(cf(3, 1, 1, 0), 1, 1, 0, 1, 1000, 0);
  endtask
  task automatic gate_test();
    pc(cf(0, 1, 0, 3), 1, 1, 0, 1, 9, 0);
    pc(cf(0, 1, 0, 3), 1, 1, 0, 1, 10, 1);
    pc(cf(0, 1, 0, 5), 1, 1, 0, 1, 29, 0);
    pc(cf(0, 1, 0, 6), 1, 1, 0, 1, 1000, 0);
    pc(cf(0, 1, 1, 0), 1, 1, 0, 1, 0, 1);
    pc(cf(0, 1, 1, 0), 1, 1, 0, 0, 1000, 0);
  endtask
  // Stop, wait for the duty threshold, brake, release, restart
  task automatic stop_case(input logic [2:0] m, input logic [3:0] b,
      input logic [2:0] t, input int ms, input logic [1:0] ph);
    int k = 0;
    @(posedge clk_sys_in);
    duty <= 7'h78;
    setup({11'h0, m, b, t, 11'h0});
    sreq <= 1'b1;
    tick(1);
    sreq <= 1'b0;
    if (t != 3'h0)
    begin
      tick(30);
      #1;
      check({phase, stopped}, {ph, 1'b0});
      @(posedge clk_sys_in);
      duty <= 7'h04;
    end
    while (stopped !== 1'b1 && k < 400)
    begin
      tick(1);
      #1;
      k++;
    end
    check(k >= ms * 10 - 1 && k <= ms * 10 + 4, 1'b1);
    check(phase, (m == 3'h1) ? 2'h3 : 2'h0);
    @(posedge clk_sys_in);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
    #1;
    check({phase, stopped}, 3'h6);
  endtask
  task automatic stop_test();
    stop_case(2, 0, 1, 1, 1);
    stop_case(3, 1, 0, 2, 2);
    stop_case(3, 0, 1, 1, 2);
    stop_case(4, 0, 1, 1, 1);
    stop_case(2, 2, 7, 5, 1);
    stop_case(0, 0, 0, 0, 0);
    stop_case(1, 0, 0, 0, 0);
    stop_case(5, 0, 0, 0, 0);
  endtask
  initial
  begin
    div_test();
    select_test();
    gate_test();
    stop_test();
    final_report();
  end
endmodule
`default_nettype wire
